// file: core/thp_defines.vh
// constants of the channel 0 payload indicator / send-message port
//
// Contract
// - pin means payload indicator when telecom bus enabled, else send-message command
// - payload indicator sampled on falling edge of telecom transmit clock
// - bus disabled and hdlc mode set: pin is the send-message command
// - command high: latch hdlc byte on each hdlc clock rising edge
// - latched bytes are framed and handed to the frame generator payload
// - command low: data ignored, continuous 0x7E flag octets sent (code still sends a held byte and a requested check trailer first)
`ifndef THP_DEFINES_VH
`define THP_DEFINES_VH
`define THP_FLAG_OCTET  8'h7E
`define THP_CRC16_POLY  32'h00008408
`define THP_CRC32_POLY  32'hEDB88320
`define THP_CRC16_INIT  32'h0000FFFF
`define THP_CRC32_INIT  32'hFFFFFFFF
`define THP_FCS16_LEN   3'h2
`define THP_FCS32_LEN   3'h4
`define THP_ONES_LIMIT  3'h5
`define THP_BIT_LAST    3'h7
`endif

// file: core/thp_sync.v
// two-flop synchroniser for signals from outside the sys_clk domain
`default_nettype none
module thp_sync #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         srst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // thp_sync
`default_nettype wire

// file: core/thp_port.v
// channel 0 transmit port: telecom payload indicator or hdlc send-message serialiser
`include "thp_defines.vh"
`default_nettype none
module thp_port (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       telecom_bus_en,
  input  wire       hdlc_mode_en,
  input  wire       crc32_sel,
  input  wire       tx_payload_indicator_in,
  input  wire       telecom_tx_clock,
  input  wire [7:0] telecom_tx_data_bus,
  input  wire       hdlc_tx_clock,
  input  wire [7:0] hdlc_tx_byte_in,
  input  wire       hdlc_append_check_cmd,
  input  wire       payload_bit_req,
  output wire [7:0] telecom_byte_out,
  output wire       telecom_payload_out,
  output wire       telecom_strobe_out,
  output wire       hdlc_bit_out,
  output wire       hdlc_bit_valid_out,
  output wire       hdlc_overrun_out
);
  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  // pin feeds both synchronisers, one copy per role; role is picked after them
  wire [9:0]  tel_s;
  wire [10:0] hd_s;

  thp_sync #(.W(10)) u_tel_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in ({telecom_tx_clock, tx_payload_indicator_in, telecom_tx_data_bus}),
    .sync_out (tel_s)
  );

  thp_sync #(.W(11)) u_hd_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in ({hdlc_tx_clock, tx_payload_indicator_in, hdlc_append_check_cmd,
                hdlc_tx_byte_in}),
    .sync_out (hd_s)
  );

  wire       tel_clk_s     = tel_s[9];
  wire       tel_pl_s      = tel_s[8];
  wire [7:0] tel_data_s    = tel_s[7:0];
  wire       hd_clk_s      = hd_s[10];
  wire       send_msg_s    = hd_s[9];
  wire       append_s      = hd_s[8];
  wire [7:0] hd_data_s     = hd_s[7:0];

  // -------------------------------------------------------------
  // mode select
  // -------------------------------------------------------------
  wire tel_active  = telecom_bus_en;
  wire hdlc_active = ~telecom_bus_en & hdlc_mode_en;

  // -------------------------------------------------------------
  // telecom bus capture
  // -------------------------------------------------------------
  reg       tel_clk_d_reg;
  reg [7:0] tel_byte_reg;
  reg       tel_payload_reg;
  reg       tel_strobe_reg;
  wire      tel_fall = tel_clk_d_reg & ~tel_clk_s;

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      tel_clk_d_reg   <= 1'b0;
      tel_byte_reg    <= 8'h00;
      tel_payload_reg <= 1'b0;
      tel_strobe_reg  <= 1'b0;
    end
    else
    begin
      tel_clk_d_reg  <= tel_clk_s;
      tel_strobe_reg <= 1'b0;
      if (tel_active && tel_fall)
      begin
        tel_byte_reg    <= tel_data_s;
        // low marks an overhead byte, relied on from the far end
        tel_payload_reg <= tel_pl_s;
        tel_strobe_reg  <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // hdlc capture and check-sequence request
  // -------------------------------------------------------------
  reg        hd_clk_d_reg;
  reg  [7:0] hold_reg;
  reg        hold_valid_reg;
  reg        overrun_reg;
  reg  [2:0] append_cnt_reg;
  reg        fcs_req_reg;
  wire       hd_rise  = ~hd_clk_d_reg & hd_clk_s;
  wire [2:0] fcs_len  = crc32_sel ? `THP_FCS32_LEN : `THP_FCS16_LEN;
  wire [2:0] append_cnt_next = append_cnt_reg + 3'h1;

  // -------------------------------------------------------------
  // serialiser
  // -------------------------------------------------------------
  reg  [7:0]  shift_reg;
  reg  [2:0]  bit_cnt_reg;
  reg         stuffed_reg;
  reg         is_data_reg;
  reg  [2:0]  ones_reg;
  reg  [31:0] crc_reg;
  reg  [23:0] fcs_shift_reg;
  reg  [2:0]  fcs_left_reg;
  reg         bit_reg;
  reg         bit_valid_reg;

  wire        loading   = (bit_cnt_reg == 3'h0);
  wire        stuff_now = stuffed_reg & (ones_reg == `THP_ONES_LIMIT);
  wire        step      = payload_bit_req & hdlc_active;
  wire        take      = step & ~stuff_now & loading & hold_valid_reg;
  wire [31:0] crc_init  = crc32_sel ? `THP_CRC32_INIT : `THP_CRC16_INIT;
  wire [31:0] crc_poly  = crc32_sel ? `THP_CRC32_POLY : `THP_CRC16_POLY;
  wire [31:0] crc_inv   = ~crc_reg;

  reg  [7:0]  cur_byte;
  reg         cur_stuffed;
  reg         cur_data;

  // next source: held byte, then trailer, else idle flag
  always @*
  begin
    cur_byte    = shift_reg;
    cur_stuffed = stuffed_reg;
    cur_data    = is_data_reg;
    if (loading)
    begin
      if (hold_valid_reg)
      begin
        cur_byte    = hold_reg;
        cur_stuffed = 1'b1;
        cur_data    = 1'b1;
      end
      else if (fcs_left_reg != 3'h0)
      begin
        cur_byte    = fcs_shift_reg[7:0];
        cur_stuffed = 1'b1;
        cur_data    = 1'b0;
      end
      else if (fcs_req_reg)
      begin
        cur_byte    = crc_inv[7:0];
        cur_stuffed = 1'b1;
        cur_data    = 1'b0;
      end
      else
      begin
        cur_byte    = `THP_FLAG_OCTET;
        cur_stuffed = 1'b0;
        cur_data    = 1'b0;
      end
    end
  end

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      hd_clk_d_reg   <= 1'b0;
      hold_reg       <= 8'h00;
      hold_valid_reg <= 1'b0;
      overrun_reg    <= 1'b0;
      append_cnt_reg <= 3'h0;
      fcs_req_reg    <= 1'b0;
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 3'h0;
      stuffed_reg    <= 1'b0;
      is_data_reg    <= 1'b0;
      ones_reg       <= 3'h0;
      crc_reg        <= `THP_CRC16_INIT;
      fcs_shift_reg  <= 24'h000000;
      fcs_left_reg   <= 3'h0;
      bit_reg        <= 1'b0;
      bit_valid_reg  <= 1'b0;
    end
    else
    begin
      hd_clk_d_reg  <= hd_clk_s;
      bit_valid_reg <= 1'b0;
      overrun_reg   <= 1'b0;
      if (!hdlc_active)
      begin
        hold_valid_reg <= 1'b0;
        fcs_req_reg    <= 1'b0;
        fcs_left_reg   <= 3'h0;
        bit_cnt_reg    <= 3'h0;
        ones_reg       <= 3'h0;
        stuffed_reg    <= 1'b0;
        crc_reg        <= crc_init;
      end
      else if (step)
      begin
        bit_valid_reg <= 1'b1;
        if (stuff_now)
        begin
          bit_reg  <= 1'b0;
          ones_reg <= 3'h0;
        end
        else
        begin
          bit_reg     <= cur_byte[0];
          shift_reg   <= {1'b0, cur_byte[7:1]};
          bit_cnt_reg <= loading ? `THP_BIT_LAST : bit_cnt_reg - 3'h1;
          stuffed_reg <= cur_stuffed;
          is_data_reg <= cur_data;
          ones_reg    <= (cur_stuffed && cur_byte[0]) ? ones_reg + 3'h1 : 3'h0;
          if (cur_data)
            crc_reg <= (crc_reg >> 1) ^ ((crc_reg[0] ^ cur_byte[0]) ? crc_poly : 32'h0);
          if (loading)
          begin
            if (hold_valid_reg)
              hold_valid_reg <= 1'b0;
            else if (fcs_left_reg != 3'h0)
            begin
              fcs_shift_reg <= {8'h00, fcs_shift_reg[23:8]};
              fcs_left_reg  <= fcs_left_reg - 3'h1;
            end
            else if (fcs_req_reg)
            begin
              fcs_shift_reg <= crc_inv[31:8];
              fcs_left_reg  <= fcs_len - 3'h1;
              fcs_req_reg   <= 1'b0;
              crc_reg       <= crc_init;
            end
          end
        end
      end
      // captures sit after the consumer so a set in the same cycle wins
      if (hdlc_active && hd_rise)
      begin
        if (send_msg_s)
        begin
          hold_reg       <= hd_data_s;
          hold_valid_reg <= 1'b1;
          overrun_reg    <= hold_valid_reg & ~take;
        end
        if (append_s)
        begin
          append_cnt_reg <= append_cnt_next;
          if (append_cnt_next == fcs_len)
            fcs_req_reg <= 1'b1;
        end
        else
          append_cnt_reg <= 3'h0;
      end
    end
  end

  assign telecom_byte_out    = tel_byte_reg;
  assign telecom_payload_out = tel_payload_reg;
  assign telecom_strobe_out  = tel_strobe_reg;
  assign hdlc_bit_out        = bit_reg;
  assign hdlc_bit_valid_out  = bit_valid_reg;
  assign hdlc_overrun_out    = overrun_reg;
endmodule // thp_port
`default_nettype wire

// file: testbench/thp_port_monitor.sv
// checker of the channel 0 port outputs
`default_nettype none
module thp_port_monitor (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       telecom_bus_en,
  input wire logic       hdlc_mode_en,
  input wire logic       payload_bit_req,
  input wire logic [7:0] telecom_byte_out,
  input wire logic       telecom_payload_out,
  input wire logic       telecom_strobe_out,
  input wire logic       hdlc_bit_out,
  input wire logic       hdlc_bit_valid_out,
  input wire logic       hdlc_overrun_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // checks
  // ----
  logic act;
  assign act = !telecom_bus_en && hdlc_mode_en;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_strobe_pulse: assert property (telecom_strobe_out |=> !telecom_strobe_out)
    else $error("strobe too long");
  a_strobe_gated: assert property (telecom_strobe_out |-> $past(telecom_bus_en))
    else $error("capture while bus off");
  // past reset guard: outputs clear during reset, not a capture
  a_capture_hold: assert property (!telecom_strobe_out && !$past(srst) |->
    $stable(telecom_byte_out) && $stable(telecom_payload_out)) else $error("byte moved");
  a_valid_req: assert property (payload_bit_req && act |=> hdlc_bit_valid_out)
    else $error("bit not given");
  a_valid_cause: assert property (hdlc_bit_valid_out |-> $past(payload_bit_req && act))
    else $error("bit without request");
  a_bit_holds: assert property (!hdlc_bit_valid_out && !$past(srst) |->
    $stable(hdlc_bit_out)) else $error("bit moved");
  a_overrun_pulse: assert property (hdlc_overrun_out |=> !hdlc_overrun_out)
    else $error("overrun too long");
  a_overrun_active: assert property (hdlc_overrun_out |-> $past(act))
    else $error("overrun while idle");
  c_overhead: cover property (telecom_strobe_out && !telecom_payload_out);
  c_bit_one: cover property (hdlc_bit_valid_out && hdlc_bit_out);
  c_overrun: cover property (hdlc_overrun_out);
endmodule // thp_port_monitor
bind thp_port thp_port_monitor thp_port_monitor_i (
  .sys_clk             (sys_clk),
  .srst                (srst),
  .telecom_bus_en      (telecom_bus_en),
  .hdlc_mode_en        (hdlc_mode_en),
  .payload_bit_req     (payload_bit_req),
  .telecom_byte_out    (telecom_byte_out),
  .telecom_payload_out (telecom_payload_out),
  .telecom_strobe_out  (telecom_strobe_out),
  .hdlc_bit_out        (hdlc_bit_out),
  .hdlc_bit_valid_out  (hdlc_bit_valid_out),
  .hdlc_overrun_out    (hdlc_overrun_out)
);
`default_nettype wire

// file: testbench/thp_far_end.sv
// far-end terminal equipment model
`default_nettype none
module thp_far_end (
  input  wire logic       tel_on,
  input  wire logic       go,
  input  wire logic [7:0] msg,
  input  wire logic       fcs_go,
  input  wire logic       crc32,
  output wire logic       pin,
  output var  logic       tclk,
  output var  logic [7:0] tdata,
  output var  logic       hclk,
  output var  logic [7:0] hbyte,
  output var  logic       fcs_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // model
  // ----
  logic ind = 1'b1;
  logic cmd = 1'b0;
  int   n = 0;
  int   k = 0;
  initial {tclk, hclk, tdata, hbyte, fcs_cmd} = 19'h0;
  assign pin = tel_on ? ind : cmd;
  // clocks stand still outside their mode
  always #16 tclk = tel_on ? !tclk : 1'b0;
  always #20 hclk = tel_on ? 1'b0 : !hclk;
  always @(posedge tclk)
  begin
    n = (n == 8) ? 0 : n + 1;
    ind = (n >= 3);
    tdata = tdata * 8'h05 + 8'h3B;
  end
  always @(negedge hclk)
  begin
    cmd = go;
    hbyte = go ? msg : ~hbyte;
    tdata = ~tdata;
    if (fcs_go && k == 0) k = crc32 ? 4 : 2;
    fcs_cmd = (k != 0);
    if (k != 0) k = k - 1;
  end
endmodule // thp_far_end
`default_nettype wire

// file: testbench/test_tx_hdlc_send_msg_payload_ind_port.sv
// self-checking bench of the channel 0 port
`default_nettype none
module test_tx_hdlc_send_msg_payload_ind_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, srst, tbe, hm, c32, req, run, tel, go, fg, hit, ovr;
  wire logic   pin, tclk, hclk, fc, tp, ts, hb, hv, ov;
  wire logic [7:0] tdata, hbyte, tb;
  int          errors, checked, cyc;
  logic [31:0] seed;
  logic [7:0]  d;
  logic [63:0] sh;
  logic [31:0] f;
  logic [63:0] fr;
  int          fl;
  logic [8:0]  q[$];
  thp_port thp_port_i (.sys_clk(sys_clk), .srst(srst), .telecom_bus_en(tbe),
    .hdlc_mode_en(hm), .crc32_sel(c32), .tx_payload_indicator_in(pin),
    .telecom_tx_clock(tclk), .telecom_tx_data_bus(tdata), .hdlc_tx_clock(hclk),
    .hdlc_tx_byte_in(hbyte), .hdlc_append_check_cmd(fc), .payload_bit_req(req),
    .telecom_byte_out(tb), .telecom_payload_out(tp), .telecom_strobe_out(ts),
    .hdlc_bit_out(hb), .hdlc_bit_valid_out(hv), .hdlc_overrun_out(ov));
  thp_far_end thp_far_end_i (.tel_on(tel), .go(go), .msg(d), .fcs_go(fg), .crc32(c32),
    .pin(pin), .tclk(tclk), .tdata(tdata), .hclk(hclk), .hbyte(hbyte), .fcs_cmd(fc));
  // ----
  // tasks
  // ----
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // expected trailer: reflected crc over one byte, inverted
  function automatic logic [31:0] fcs_of(input logic [7:0] v, input logic wide);
    logic [31:0] c;
    c = wide ? 32'hFFFFFFFF : 32'h0000FFFF;
    for (int i = 0; i < 8; i++)
      c = (c >> 1) ^ ((c[0] ^ v[i]) ? (wide ? 32'hEDB88320 : 32'h00008408) : 32'h0);
    return ~c;
  endfunction
  // five ones in a row would draw a stuffed zero
  function automatic logic runs5(input logic [39:0] v, input int n);
    logic r;
    r = 1'b0;
    for (int i = 0; i + 5 <= n; i++)
      if (&v[i +: 5]) r = 1'b1;
    return r;
  endfunction
  // idle stream: any bit phase of repeated flags
  function automatic logic idle(input logic [63:0] w);
    logic [15:0] p;
    logic        r;
    p = 16'h7E7E;
    r = 1'b0;
    for (int i = 0; i < 8; i++)
      if (w === {8{p[i +: 8]}}) r = 1'b1;
    return r;
  endfunction
  task automatic hdlc_cmd(input logic m, input logic fcs, input int nb);
    go <= m;
    fg <= fcs;
    repeat (nb) @(negedge hclk);
    @(posedge sys_clk);
    {go, fg} <= 2'b00;
  endtask
  // ----
  // monitors
  // ----
  initial sys_clk = 1'b0;
  always #2 sys_clk = !sys_clk;
  always @(negedge tclk) if (tbe) q.push_back({pin, tdata});
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      finish_test();
    end
    if (hv) sh <= {hb, sh[63:1]};
    if ((sh >> (64 - fl)) === fr) hit <= 1'b1;
    if (ov) ovr <= 1'b1;
    if (ts) chk({tp, tb} === q.pop_front(), "capture");
    req <= run && ($random(seed) & 1) == 1;
  end
  // ----
  // sequence
  // ----
  initial
  begin
    seed = 32'heb53;
    {srst, tbe, hm, c32, req, run, tel, go, fg, hit, ovr} = 11'h400;
    {errors, checked, cyc, fl, d, sh, f, fr} = 0;
    repeat (6) @(posedge sys_clk);
    {srst, tbe, tel} <= 3'b011;
    repeat (600) @(posedge sys_clk);
    tel <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk(q.size() == 0, "captures lost");
    {tbe, hm, run} <= 3'b011;
    repeat (300) @(posedge sys_clk);
    chk(idle(sh), "idle flags");
    repeat (4)
    begin
      d = 8'($random(seed)) & 8'h77; // no five ones, so no stuffing
      fr = {40'h0, 8'h7E, d, 8'h7E};
      fl = 24;
      hit = 1'b0;
      hdlc_cmd(1'b1, 1'b0, 1);
      repeat (200) @(posedge sys_clk);
      chk(hit, "byte framing");
    end
    hdlc_cmd(1'b1, 1'b0, 6);
    repeat (300) @(posedge sys_clk);
    chk(ovr, "overrun");
    for (int i = 0; i < 2; i++)
    begin
      // width changes only while hdlc mode is off, so the crc restarts clean
      {hm, c32} <= {1'b0, i[0]};
      repeat (4) @(posedge sys_clk);
      hm <= 1'b1;
      repeat (100) @(posedge sys_clk);
      run <= 1'b0;
      d = 8'($random(seed));
      f = fcs_of(d, i[0]);
      while (runs5({f, d}, i ? 40 : 24))
      begin
        d = 8'($random(seed));
        f = fcs_of(d, i[0]);
      end
      fr = i ? {8'h00, 8'h7E, f, d, 8'h7E} : {24'h0, 8'h7E, f[15:0], d, 8'h7E};
      fl = i ? 56 : 40;
      hit = 1'b0;
      // byte and trailer request land while paused: no flag between them
      hdlc_cmd(1'b1, 1'b1, 1);
      repeat (60) @(posedge sys_clk);
      run <= 1'b1;
      repeat (400) @(posedge sys_clk);
      chk(hit, "check trailer");
      chk(idle(sh), "flags after check");
    end
    hm <= 1'b0;
    repeat (100) @(posedge sys_clk);
    finish_test();
  end
endmodule // test_tx_hdlc_send_msg_payload_ind_port
`default_nettype wire
